// ---- design/punch_pkg.sv ----
`default_nettype none
package punch_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 100;
  localparam int LOAD_PULSE_NS   = 2000;
  localparam int LOAD_PULSE_CYC  = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PUNCH_GATE_MS   = 4;
  localparam int PUNCH_GATE_CYC  = PUNCH_GATE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FUNC_BLOCK_MS   = 70;
  localparam int FUNC_BLOCK_CYC  = FUNC_BLOCK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int READY_WIN_MS    = 10;
  localparam int READY_WIN_CYC   = READY_WIN_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W           = 20;
  // ************************************************************
  // Data and function words
  // ************************************************************
  localparam int DATA_W          = 8;
  localparam int FIFO_DEPTH      = 16;
  localparam int FUNC_W          = 6;
  localparam int FUNC_BIT_DEVICE = 0;
  localparam int FUNC_BIT_SET    = 2;
  localparam logic [DATA_W-1:0] OUT_REG_RESET = 8'h00;
  // ************************************************************
  // Punch gate sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    GATE_IDLE = 3'b001,
    GATE_WAIT = 3'b010,
    GATE_ON   = 3'b100
  } gate_state_type;
endpackage
`default_nettype wire

// ---- design/punch_sync.sv ----
`default_nettype none
module punch_sync
  import punch_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic stage1;
  logic stage2;
  logic last;

  // ************************************************************
  // Two-stage synchroniser with edge detection on the second stage.
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      last   <= 1'b0;
    end else if (clk_en) begin
      stage1 <= async_in;
      stage2 <= stage1;
      last   <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = clk_en & stage2 & ~last;
  assign fall  = clk_en & ~stage2 & last;
endmodule
`default_nettype wire

// ---- design/byte_fifo.sv ----
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = clk_en & in_valid & in_ready;
  assign pop       = clk_en & out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ************************************************************
  // Pointers and occupancy.
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end else begin
        if (push) begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (pop) begin
          rd_ptr <= rd_ptr + 1'b1;
        end
        if (push && !pop) begin
          count <= count + 1'b1;
        end else if (pop && !push) begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/tape_perforator_output_control.sv ----
`default_nettype none
module tape_perforator_output_control
  import punch_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic              global_clear,
  input  wire logic              punch_clear,
  input  wire logic              copy_mode,
  input  wire logic              serializer_busy,
  input  wire logic              print_enable,
  input  wire logic              flywheel_sync,
  input  wire logic [DATA_W-1:0] host_data,
  input  wire logic              host_byte_acknowledge,
  input  wire logic [FUNC_W-1:0] function_word,
  input  wire logic              function_word_acknowledge,
  input  wire logic              function_word_wanted,
  output logic                   host_byte_request_alias,
  output logic                   function_word_request,
  output logic [DATA_W-1:0]      perforation_data,
  output logic                   perforation_gate,
  output logic                   motor_start,
  output logic                   punch_indicator,
  output logic                   tape_feed_indicator,
  output logic                   punch_ready,
  output logic                   fifo_overflow_guard
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic           sync_level;
  logic           sync_rise;
  logic           sync_fall;
  logic           ack_rise;
  logic           fack_rise;
  logic           punch_active;
  logic           advance_pending;
  logic [DATA_W-1:0] out_reg;
  logic [CNT_W-1:0]  gate_cnt;
  logic [CNT_W-1:0]  func_cnt;
  logic [CNT_W-1:0]  win_cnt;
  logic [4:0]        load_cnt;
  logic [4:0]        fpulse_cnt;
  logic           load_pulse;
  logic           func_pulse;
  logic           seen_first_sync;
  logic           gate_end;
  logic           reg_clear;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic           fifo_pop;
  logic           func_stop;
  logic           func_start;
  gate_state_type gate_state;

  function automatic logic is_func(input logic [FUNC_W-1:0] w, input logic set_bit);
    is_func = w[FUNC_BIT_DEVICE] & (w[FUNC_BIT_SET] == set_bit);
  endfunction

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  punch_sync u_sync_flywheel (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (flywheel_sync),
    .level    (sync_level),
    .rise     (sync_rise),
    .fall     (sync_fall)
  );
  punch_sync u_sync_byte_ack (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (host_byte_acknowledge),
    .level    (),
    .rise     (ack_rise),
    .fall     ()
  );
  punch_sync u_sync_func_ack (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (function_word_acknowledge),
    .level    (),
    .rise     (fack_rise),
    .fall     ()
  );

  // ************************************************************
  // Byte buffer between host and output register
  // ************************************************************
  // The host byte enters a small buffer so the load pulse timing is decoupled
  // from the host; the buffer never holds more than one byte because requests
  // are withheld while it holds a byte, during the load pulse and while advance is pending.
  assign fifo_pop = load_pulse && (load_cnt == 5'(LOAD_PULSE_CYC - 1));
  byte_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .flush     (global_clear),
    .in_valid  (ack_rise & ~copy_mode),
    .in_ready  (fifo_in_ready),
    .in_data   (host_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );
  assign fifo_overflow_guard = ~fifo_in_ready;

  // ************************************************************
  // Load pulse
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      load_pulse <= 1'b0;
      load_cnt   <= '0;
    end else if (clk_en) begin
      if (global_clear) begin
        load_pulse <= 1'b0;
        load_cnt   <= '0;
      end else if (!load_pulse && fifo_out_valid && !copy_mode) begin
        load_pulse <= 1'b1;
        load_cnt   <= '0;
      end else if (load_pulse) begin
        if (load_cnt == 5'(LOAD_PULSE_CYC - 1)) begin
          load_pulse <= 1'b0;
        end
        load_cnt <= load_cnt + 5'd1;
      end
    end
  end

  // ************************************************************
  // Output register
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_reg <= OUT_REG_RESET;
    end else if (clk_en) begin
      if (load_pulse && !copy_mode) begin
        out_reg <= fifo_out_data;
      end else if (reg_clear || global_clear) begin
        out_reg <= OUT_REG_RESET;
      end
    end
  end

  // ************************************************************
  // Punch active and punch ready
  // ************************************************************
  assign func_stop  = func_pulse && fpulse_cnt == 5'd0 && is_func(function_word, 1'b0);
  assign func_start = func_pulse && fpulse_cnt == 5'd0 && is_func(function_word, 1'b1);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      punch_active <= 1'b0;
    end else if (clk_en) begin
      if (global_clear || punch_clear || func_stop) begin
        punch_active <= 1'b0;
      end else if (func_start) begin
        punch_active <= 1'b1;
      end
    end
  end
  assign motor_start     = punch_active;
  assign punch_indicator = punch_active;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      punch_ready     <= 1'b0;
      seen_first_sync <= 1'b0;
      win_cnt         <= '0;
    end else if (clk_en) begin
      if (!punch_active || global_clear) begin
        punch_ready     <= 1'b0;
        seen_first_sync <= 1'b0;
        win_cnt         <= '0;
      end else if (sync_rise) begin
        if (seen_first_sync && win_cnt < CNT_W'(READY_WIN_CYC)) begin
          punch_ready <= 1'b1;
        end
        seen_first_sync <= 1'b1;
        win_cnt         <= '0;
      end else if (seen_first_sync && win_cnt < CNT_W'(READY_WIN_CYC)) begin
        win_cnt <= win_cnt + 1'b1;
      end
    end
  end

  // ************************************************************
  // Advance pending flag
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      advance_pending <= 1'b0;
    end else if (clk_en) begin
      if (global_clear) begin
        advance_pending <= 1'b0;
      end else if (load_pulse && punch_ready) begin
        advance_pending <= 1'b1;
      end else if (gate_state == GATE_ON && sync_fall) begin
        advance_pending <= 1'b0;
      end
    end
  end
  assign tape_feed_indicator = advance_pending;

  // ************************************************************
  // Punch gate sequencer
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gate_state <= GATE_IDLE;
      gate_cnt   <= '0;
    end else if (clk_en) begin
      case (gate_state)
        GATE_IDLE: begin
          if (advance_pending && !global_clear) begin
            gate_state <= GATE_WAIT;
          end
        end
        GATE_WAIT: begin
          if (global_clear || !advance_pending) begin
            gate_state <= GATE_IDLE;
          end else if (sync_rise) begin
            gate_state <= GATE_ON;
            gate_cnt   <= '0;
          end
        end
        GATE_ON: begin
          if (global_clear || gate_cnt == CNT_W'(PUNCH_GATE_CYC - 1)) begin
            gate_state <= GATE_IDLE;
          end
          gate_cnt <= gate_cnt + 1'b1;
        end
        default: begin
          gate_state <= GATE_IDLE;
        end
      endcase
    end
  end
  assign gate_end = (gate_state != GATE_ON);

  // Perforation lines are gated copies of the register; the register is a
  // flip-flop, so the lines change only with the gate or a load.
  assign perforation_gate = (gate_state == GATE_ON);
  assign perforation_data = perforation_gate ? out_reg : '0;

  // ************************************************************
  // Register clear and byte request
  // ************************************************************
  assign reg_clear = gate_end && !advance_pending && !print_enable;
  assign host_byte_request_alias = !copy_mode && !serializer_busy && punch_ready
                                   && reg_clear && !load_pulse && !fifo_out_valid;

  // ************************************************************
  // Function acknowledge pulse and request block
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      func_pulse <= 1'b0;
      fpulse_cnt <= '0;
    end else if (clk_en) begin
      if (fack_rise && !copy_mode) begin
        func_pulse <= 1'b1;
        fpulse_cnt <= '0;
      end else if (func_pulse) begin
        if (fpulse_cnt == 5'(LOAD_PULSE_CYC - 1)) begin
          func_pulse <= 1'b0;
        end
        fpulse_cnt <= fpulse_cnt + 5'd1;
      end
    end
  end

  // Reset starts the block window too, so the host waits 70 ms after power-up.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      func_cnt <= CNT_W'(FUNC_BLOCK_CYC);
    end else if (clk_en) begin
      if (global_clear || (fack_rise && !copy_mode)) begin
        func_cnt <= CNT_W'(FUNC_BLOCK_CYC);
      end else if (func_cnt != '0) begin
        func_cnt <= func_cnt - 1'b1;
      end
    end
  end
  assign function_word_request = function_word_wanted && !copy_mode && (func_cnt == '0);

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_gate_start;
    clk_en && advance_pending && gate_state == GATE_WAIT && sync_rise && !global_clear;
  endsequence
  sequence s_gate_open;
    perforation_gate[*8];
  endsequence

  AST_GATE_START: assert property (@(posedge core_clk) disable iff (!resetn)
    s_gate_start |=> s_gate_open) else $error("punch gate did not open");
  AST_DATA_FOLLOW: assert property (@(posedge core_clk) disable iff (!resetn)
    perforation_gate |-> perforation_data == out_reg) else $error("perforation data mismatch");
  AST_REG_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && reg_clear && !load_pulse |=> out_reg == OUT_REG_RESET) else $error("output register not cleared");
  AST_NO_GATE_DATA: assert property (@(posedge core_clk) disable iff (!resetn)
    !perforation_gate |-> perforation_data == '0) else $error("perforation without gate");
  AST_REQ_NOT_READY: assert property (@(posedge core_clk) disable iff (!resetn)
    !punch_ready |-> !host_byte_request_alias) else $error("request without ready");
  AST_REQ_PENDING: assert property (@(posedge core_clk) disable iff (!resetn)
    advance_pending |-> !host_byte_request_alias) else $error("request while advance pending");
  AST_PRINT_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    print_enable |-> !host_byte_request_alias && !reg_clear) else $error("printer hold failed");
  AST_STOP_WORD: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && func_stop && !func_start |=> !punch_active && !motor_start) else $error("stop word ignored");
  AST_READY_DROP: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && !punch_active |=> !punch_ready) else $error("ready survived punch stop");
  AST_GCLR: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && global_clear |=> !advance_pending && !punch_active && !function_word_request)
    else $error("global clear incomplete");
  AST_FUNC_BLOCK: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && fack_rise && !copy_mode |=> !function_word_request[*8]) else $error("function request not blocked");
endmodule
`default_nettype wire

// ---- tb/host_model.sv ----
`default_nettype none
module host_model
  import punch_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              serve,
  input  wire logic [3:0]        delay,
  input  wire logic [DATA_W-1:0] byte_in,
  input  wire logic              host_byte_request_alias,
  output logic      [DATA_W-1:0] host_data,
  output logic                   host_byte_acknowledge
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Host answering byte requests
  // ************************************************************
  // Released data lines carry the inverse byte, so a late capture never sees a stale match.
  initial begin
    host_data = 8'h00;
    host_byte_acknowledge = 1'b0;
    forever begin
      @(negedge core_clk);
      if (serve && host_byte_request_alias) begin
        host_data = byte_in;
        repeat (delay) @(negedge core_clk);
        host_byte_acknowledge = 1'b1;
        repeat (4) @(negedge core_clk);
        while (host_byte_request_alias) @(negedge core_clk);
        host_byte_acknowledge = 1'b0;
        host_data = ~byte_in;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top
  import punch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              core_clk, resetn, global_clear, punch_clear, copy_mode, serializer_busy;
  logic              print_enable, flywheel_sync, function_word_acknowledge, serve, gate_q;
  logic              host_byte_acknowledge, host_byte_request_alias, function_word_request;
  logic              perforation_gate, motor_start, punch_indicator, tape_feed_indicator;
  logic              punch_ready, fifo_overflow_guard;
  logic [FUNC_W-1:0] function_word;
  logic [DATA_W-1:0] host_data, byte_in, perforation_data;
  logic [3:0]        delay;
  int                fails, compares, gate_len;
  logic [DATA_W-1:0] expq[$];

  tape_perforator_output_control DUT (.core_clk, .resetn, .clk_en(1'b1), .global_clear, .punch_clear,
    .copy_mode, .serializer_busy, .print_enable, .flywheel_sync, .host_data, .host_byte_acknowledge,
    .function_word, .function_word_acknowledge, .function_word_wanted(1'b1), .host_byte_request_alias,
    .function_word_request, .perforation_data, .perforation_gate, .motor_start, .punch_indicator,
    .tape_feed_indicator, .punch_ready, .fifo_overflow_guard);
  host_model host (.core_clk, .serve, .delay, .byte_in, .host_byte_request_alias, .host_data,
    .host_byte_acknowledge);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ************************************************************
  // Compare and drive tasks
  // ************************************************************
  task automatic note(input logic bad, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (bad) begin
      fails++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    note(got !== exp, 32'(got), 32'(exp));
  endtask
  task automatic chk_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    note(got !== exp, 32'(got), 32'(exp));
  endtask
  task automatic chk_count(input int got, input int exp);
    note(got != exp, got, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic func(input logic [FUNC_W-1:0] w);
    function_word = w;
    function_word_acknowledge = 1'b1;
    cyc(6);
    function_word_acknowledge = 1'b0;
    cyc(40);
    chk_flag(function_word_request, 1'b0);
  endtask
  task automatic sync_pulse();
    flywheel_sync = 1'b1;
    cyc(30);
    flywheel_sync = 1'b0;
    cyc(30);
  endtask
  task automatic start_punch(input logic [FUNC_W-1:0] w);
    func(w);
    chk_flag(motor_start, 1'b1);
    chk_flag(punch_indicator, 1'b1);
    sync_pulse();
    sync_pulse();
    chk_flag(punch_ready, 1'b1);
  endtask
  task automatic send_byte(input logic keep);
    byte_in = 8'($urandom);
    delay = 4'($urandom % 8);
    if (keep) expq.push_back(byte_in);
    serve = 1'b1;
    cyc(40);
    serve = 1'b0;
    chk_flag(host_byte_request_alias, 1'b0);
    chk_flag(tape_feed_indicator, 1'b1);
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ************************************************************
  // Result watcher and test sequence
  // ************************************************************
  always @(posedge core_clk) begin
    gate_q <= perforation_gate;
    if (perforation_gate === 1'b1) gate_len <= (gate_q === 1'b1) ? gate_len + 1 : 1;
    if (perforation_gate === 1'b1 && gate_q !== 1'b1) begin
      chk_flag(expq.size() > 0, 1'b1);
      if (expq.size() > 0) chk_byte(perforation_data, expq.pop_front());
    end
    if (perforation_gate !== 1'b1 && gate_q === 1'b1) chk_count(gate_len, PUNCH_GATE_CYC);
  end
  initial begin
    #(60000 * 100);
    fails++;
    close_out();
  end
  initial begin
    {resetn, global_clear, punch_clear, copy_mode, serializer_busy, print_enable} = 6'h00;
    {flywheel_sync, function_word_acknowledge, serve, function_word, byte_in, delay} = '0;
    fails = 0;
    compares = 0;
    void'($urandom(4135));
    cyc(4);
    resetn = 1'b1;
    cyc(2);
    chk_flag(motor_start, 1'b0);
    chk_flag(host_byte_request_alias, 1'b0);
    start_punch(6'h05);
    chk_flag(host_byte_request_alias, 1'b1);
    for (int i = 0; i < 3; i++) begin
      {copy_mode, serializer_busy, print_enable} = 3'b100 >> i;
      cyc(2);
      chk_flag(host_byte_request_alias, 1'b0);
    end
    {copy_mode, serializer_busy, print_enable} = 3'b000;
    $display("test start done");
    send_byte(1'b1);
    chk_byte(perforation_data, 8'h00);
    sync_pulse();
    chk_flag(perforation_gate, 1'b1);
    chk_flag(tape_feed_indicator, 1'b0);
    for (int i = 0; i < 45000 && perforation_gate === 1'b1; i++) @(negedge core_clk);
    cyc(3);
    chk_byte(perforation_data, 8'h00);
    chk_flag(host_byte_request_alias, 1'b1);
    $display("test punch done");
    func(6'h01);
    chk_flag(motor_start, 1'b0);
    chk_flag(punch_indicator, 1'b0);
    chk_flag(punch_ready, 1'b0);
    chk_flag(host_byte_request_alias, 1'b0);
    $display("test stop done");
    func(6'h0D);
    chk_flag(motor_start, 1'b1);
    punch_clear = 1'b1;
    cyc(5);
    punch_clear = 1'b0;
    cyc(5);
    chk_flag(motor_start, 1'b0);
    chk_flag(punch_ready, 1'b0);
    $display("test punch clear done");
    start_punch(6'h05);
    send_byte(1'b0);
    global_clear = 1'b1;
    cyc(5);
    global_clear = 1'b0;
    cyc(5);
    chk_flag(tape_feed_indicator, 1'b0);
    chk_flag(motor_start, 1'b0);
    chk_byte(perforation_data, 8'h00);
    chk_flag(function_word_request, 1'b0);
    chk_flag(fifo_overflow_guard, 1'b0);
    chk_count(expq.size(), 0);
    $display("test global clear done");
    close_out();
  end
endmodule
`default_nettype wire
